// >>> bench/port_board_pins.sv
`timescale 1ns/10ps

// Board side of a group of pins: the chip wins where it enables its driver.
module port_board_pins (
  input wire logic [31:0] drv,
  input wire logic [31:0] oe,
  input wire logic [31:0] ext,
  output logic [31:0] lvl
);
  // A released pin shows the board level, so a stale drive can never read back.
  assign lvl = (oe & drv) | (~oe & ext);
endmodule : port_board_pins

// >>> bench/port_data_and_pin_function_bench.sv
`timescale 1ns/10ps

module port_data_and_pin_function_bench;
  logic mclk, rst, host_boot, hsel, hwrite, hreadyout, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, q, d;
  logic [31:0] dir [3], gen [3], ext [4];
  wire [31:0] pout [4], poe [4], lvl [4];
  logic [6:0] hd_out, hd_oe, hd_in;
  logic hint, hreq, hrdy, stx, cs, rs, ws, rds, en, md;
  logic [15:0] gsel, cf1, cf2;
  logic [15:0] mem [4];
  int n_fail = 0, tests_run = 0, r;
  localparam logic [7:0] OFF [4] = '{8'h00, 8'h04, 8'h08, 8'h0c};
  localparam logic [15:0] MSK [4] = '{16'h03ff, 16'h3fff, 16'h001f, 16'hffff};
  localparam logic [31:0] WM [3] = '{32'h3ff, 32'h3fff, 32'h1fffff};
  localparam int PRT [4] = '{0, 1, 2, 2};
  localparam int SH [4] = '{0, 0, 16, 0};
  wire [60:0] pe_got = {gsel, poe[3][15:0], pout[3][15:0] & poe[3][15:0], md, en, cs, rs, ws, rds, hd_in};

  port_data_and_pin_function u_port_data_and_pin_function (
    .mclk(mclk), .rst(rst), .host_boot(host_boot), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .pa_dir(dir[0][9:0]), .pa_gen(gen[0][9:0]), .pa_pin_in(lvl[0][9:0]),
    .pa_pin_out(pout[0][9:0]), .pa_pin_oe(poe[0][9:0]), .pb_dir(dir[1][13:0]), .pb_gen(gen[1][13:0]),
    .pb_pin_in(lvl[1][13:0]), .pb_pin_out(pout[1][13:0]), .pb_pin_oe(poe[1][13:0]),
    .pc_dir(dir[2][20:0]), .pc_gen(gen[2][20:0]), .pc_pin_in(lvl[2][20:0]), .pc_pin_out(pout[2][20:0]),
    .pc_pin_oe(poe[2][20:0]), .pe_pin_in(lvl[3][15:0]), .pe_gen_sel(gsel), .pe_fn_out(pout[3][15:0]),
    .pe_fn_oe(poe[3][15:0]), .host_if_data_out(hd_out), .host_if_data_oe(hd_oe), .host_if_interrupt(hint),
    .host_if_transfer_request(hreq), .host_if_ready(hrdy), .serial0_transmit(stx), .host_if_data_in(hd_in),
    .host_if_chip_select(cs), .host_if_reg_select(rs), .host_if_write_strobe(ws),
    .host_if_read_strobe(rds), .host_if_enable(en), .host_if_mode_input(md));

  // Board models for ports A, B, C and the lower port E pins.
  for (genvar p = 0; p < 4; p++) begin : g_pin
    port_board_pins u_port_board_pins (.drv(pout[p]), .oe(poe[p]), .ext(ext[p]), .lvl(lvl[p]));
  end

  // Free-running clock.
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // One transfer; the bus may stretch it, so both phases wait on ready.
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] v, output logic [31:0] o);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= v;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    o = hrdata;
  endtask : bus

  task automatic check_rd(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t read %h expected %h", $time, got, exp);
    end
  endtask : check_rd

  task automatic check_sig(input logic [60:0] got, input logic [60:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t pins %h expected %h", $time, got, exp);
    end
  endtask : check_sig

  task automatic do_reset(input logic b);
    @(posedge mclk);
    rst <= 1'b1;
    host_boot <= b;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
  endtask : do_reset

  // Sets both select words, then shakes the port E pins and every host-side signal.
  task automatic pe_set(input logic [15:0] f1, input logic [15:0] f2);
    cf1 = f1;
    cf2 = f2;
    bus(8'h10, 1'b1, {16'h0, f1}, q);
    bus(8'h14, 1'b1, {16'h0, f2}, q);
    ext[3] <= $urandom;
    {hd_out, hd_oe, hint, hreq, hrdy, stx} <= 18'($urandom);
    repeat (3) @(posedge mclk);
    #1;
  endtask : pe_set

  // Read of a data word: live pin for general inputs, stored bit elsewhere.
  function automatic logic [15:0] rd_exp(int i);
    logic [31:0] ld;
    ld = gen[PRT[i]] & ~dir[PRT[i]];
    return MSK[i] & ((mem[i] & ~ld[SH[i] +: 16]) | (ext[PRT[i]][SH[i] +: 16] & ld[SH[i] +: 16]));
  endfunction : rd_exp

  // Routing of the lower port E pins for given select words.
  function automatic logic [60:0] pe_exp(logic [15:0] f1, logic [15:0] f2);
    logic [15:0] s, g, oe, o, e;
    for (int i = 0; i < 7; i++) s[8+i] = f1[2*i];
    for (int i = 0; i < 8; i++) s[i] = f2[2*i];
    s[15] = f1[15:14] == 2'b01;
    g = ~s;
    g[15] = f1[15:14] == 2'b00;
    e = ext[3][15:0];
    e[15:9] = (hd_oe & hd_out) | (~hd_oe & e[15:9]);
    oe = {s[15] ? hd_oe[6] : f1[15:14] == 2'b10, hd_oe[5:0] & s[14:9], 4'h0, s[4], 1'b0, s[2:1], 1'b0};
    o = {s[15] ? hd_out[6] : stx, hd_out[5:0], 4'h0, hint, 1'b0, hreq, hrdy, 1'b0} & oe;
    return {g, oe, o, s[3] & e[3], s[0] & e[0], s[8:5] & e[8:5], e[15:9] & s[15:9]};
  endfunction : pe_exp

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  // Watchdog well beyond the few hundred cycles the tests need.
  initial begin
    #400000;
    n_fail++;
    stop_test();
  end

  initial begin
    {rst, hsel, hwrite, host_boot, hint, hreq, hrdy, stx} = 8'h80;
    {htrans, hsize, haddr, hwdata, hd_out, hd_oe} = {2'b00, 3'b010, 78'h0};
    dir = '{3{32'h0}};
    gen = '{3{32'h0}};
    void'($urandom(32'h1f0267d0));
    ext = '{4{$urandom}};
    do_reset(1'b0);
    for (int i = 0; i < 4; i++) begin
      mem[i] = 16'h0;
      bus(OFF[i], 1'b0, 32'h0, q);
      check_rd(q, 32'h0);
    end
    check_rd({30'h0, hreadyout, hresp}, 32'h2);
    bus(8'h14, 1'b0, 32'h0, q);
    check_rd(q, 32'h40);
    check_sig(pe_got, pe_exp(16'h0000, 16'h0040));
    $display("reset values done");
    for (int k = 0; k < 48; k++) begin
      r = $urandom % 4;
      d = $urandom;
      for (int p = 0; p < 3; p++) begin
        dir[p] <= $urandom;
        gen[p] <= $urandom;
        ext[p] <= $urandom;
      end
      bus(OFF[r], 1'b1, d, q);
      mem[r] = d[15:0] & MSK[r];
      bus(OFF[r], 1'b0, 32'h0, q);
      check_rd(q, {16'h0, rd_exp(r)});
      check_sig(61'(pout[PRT[r]][SH[r] +: 16] & MSK[r]), 61'(mem[r]));
      check_sig(61'(poe[PRT[r]] & WM[PRT[r]]), 61'(gen[PRT[r]] & dir[PRT[r]] & WM[PRT[r]]));
    end
    bus(8'h18, 1'b1, 32'hffffffff, q);
    bus(8'h18, 1'b0, 32'h0, q);
    check_rd(q, 32'h0);
    $display("data registers done");
    pe_set(16'h5555, 16'h5555);
    check_sig(pe_got, pe_exp(cf1, cf2));
    pe_set(16'h0001, 16'h5400);
    check_sig(pe_got, pe_exp(cf1, cf2));
    pe_set(16'h0000, 16'h0114);
    check_sig(pe_got, pe_exp(cf1, cf2));
    pe_set(16'h0000, 16'h0001);
    check_sig(pe_got, pe_exp(cf1, cf2));
    pe_set(16'h8000, 16'h0000);
    check_sig(pe_got, pe_exp(cf1, cf2));
    pe_set(16'h4000, 16'hffff);
    check_sig(pe_got, pe_exp(cf1, 16'h5555));
    bus(8'h10, 1'b1, 32'h0000c000, q);
    bus(8'h10, 1'b0, 32'h0, q);
    check_rd(q, 32'h4000);
    bus(8'h14, 1'b0, 32'h0, q);
    check_rd(q, 32'h5555);
    $display("pin functions done");
    do_reset(1'b1);
    bus(8'h10, 1'b0, 32'h0, q);
    check_rd(q, 32'h5555);
    pe_set(16'h5555, 16'h0000);
    check_sig(pe_got, pe_exp(cf1, cf2));
    $display("host boot done");
    stop_test();
  end
endmodule : port_data_and_pin_function_bench

// >>> bench/port_pfc_props.sv
`timescale 1ns/10ps

module port_pfc_props #(
  parameter int PA_W = 10,
  parameter int PB_W = 14,
  parameter int PC_W = 21
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic [PA_W-1:0] pa_dir,
  input wire logic [PA_W-1:0] pa_gen,
  input wire logic [PA_W-1:0] pa_pin_in,
  input wire logic [PA_W-1:0] pa_pin_out,
  input wire logic [PA_W-1:0] pa_pin_oe,
  input wire logic [15:0] pe_pin_in,
  input wire logic [15:0] pe_gen_sel,
  input wire logic [15:0] pe_fn_out,
  input wire logic [15:0] pe_fn_oe,
  input wire logic host_if_interrupt,
  input wire logic host_if_chip_select,
  input wire logic host_if_enable,
  input wire logic host_if_mode_input
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  // Accepted transfers, and reads of the port A data word in particular.
  wire take = hsel && hready && htrans[1];
  wire rd_a = take && !hwrite && haddr[7:0] == 8'h00;

  a_reset_clear: assert property (
    $past(rst) |-> pa_pin_out == '0 && pa_pin_oe == '0 && pe_gen_sel == 16'hffff)
    else $error("state not cleared by reset");
  a_oe_follows_dir: assert property (!$past(rst) |-> pa_pin_oe == $past(pa_gen & pa_dir))
    else $error("port A enable does not follow direction");
  a_write_drives: assert property (
    take && hwrite && haddr[7:0] == 8'h00 ##1 1'b1 |=> pa_pin_out == $past(hwdata[PA_W-1:0]))
    else $error("written data not on pins");
  a_input_read: assert property (
    rd_a |=> ((hrdata[PA_W-1:0] ^ $past(pa_pin_in)) & $past(pa_gen & ~pa_dir)) == '0)
    else $error("input pin not read live");
  a_stored_read: assert property (
    rd_a |=> ((hrdata[PA_W-1:0] ^ pa_pin_out) & ~$past(pa_gen & ~pa_dir)) == '0)
    else $error("stored bit not read back");
  a_upper_zero: assert property ($past(take && !hwrite) |-> hrdata[31:16] == '0)
    else $error("upper read half not zero");
  a_porta_width: assert property (rd_a |=> hrdata[15:PA_W] == '0)
    else $error("port A reserved bits set");
  a_int_route: assert property (
    !$past(rst) && !$past(rst, 2) && !pe_gen_sel[4] |-> pe_fn_oe[4] && pe_fn_out[4] == $past(host_if_interrupt))
    else $error("interrupt not routed");
  a_cs_route: assert property (
    !$past(rst) |-> host_if_chip_select == (!pe_gen_sel[8] && $past(pe_pin_in[8])))
    else $error("chip select routing wrong");
  a_mode_route: assert property (
    !$past(rst) |-> host_if_mode_input == (!pe_gen_sel[3] && $past(pe_pin_in[3])))
    else $error("mode input routing wrong");
  a_enable_quiet: assert property (pe_gen_sel[0] |-> !host_if_enable && !pe_fn_oe[0])
    else $error("enable active in port use");
endmodule : port_pfc_props

bind port_data_and_pin_function port_pfc_props #(.PA_W(PA_W), .PB_W(PB_W), .PC_W(PC_W)) u_port_pfc_props (
  .mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .pa_dir(pa_dir), .pa_gen(pa_gen), .pa_pin_in(pa_pin_in),
  .pa_pin_out(pa_pin_out), .pa_pin_oe(pa_pin_oe), .pe_pin_in(pe_pin_in), .pe_gen_sel(pe_gen_sel),
  .pe_fn_out(pe_fn_out), .pe_fn_oe(pe_fn_oe), .host_if_interrupt(host_if_interrupt),
  .host_if_chip_select(host_if_chip_select), .host_if_enable(host_if_enable),
  .host_if_mode_input(host_if_mode_input));

// >>> hdl/port_data_and_pin_function.sv
// Contract
// - Pin 15 field: 00 port, 01 host data bit 6, 10 serial transmit; 11 prohibited.
// - Pins 14 to 9: bit 1 selects host data bits 5 to 0, 0 port.
// - Pins 8,7,6,5 at 1 route chip-select, register-select, write, read strobe inputs.
// - Pins 4,2,1 at 1 drive host interrupt, transfer request, ready outputs.
// - Pin 0 at 1 is the host enable input; 0 gives port use.
// - Pin 3 select resets to 1 (host mode input); 0 gives port use.
// - Reserved bits read 0; software writes 0 to them.
// - Port widths are A 10, B 14, C 21, D 8, E 25 pins.
// - Port A data is 16 bits, bits 9..0 are pins 25..16, rest reserved.
// - Port B data bits 13..0 map to pins 13..0; upper two reserved.
// - Port C split: high bits 4..0 pins 20..16, low holds pins 15..0.
// - General output: written data drives pin, read returns stored value.
// - General input: read returns pin state; write stored without pin effect.
// - Other function: read returns stored value, write has no pin effect.
// - Direction 1 means output, 0 input, only in general port use.
//
// The AHB-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`include "port_pfc_regs.svh"

module port_data_and_pin_function #(
  parameter int PA_W = 10,
  parameter int PB_W = 14,
  parameter int PC_W = 21
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic host_boot,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [PA_W-1:0] pa_dir,
  input wire logic [PA_W-1:0] pa_gen,
  input wire logic [PA_W-1:0] pa_pin_in,
  output logic [PA_W-1:0] pa_pin_out,
  output logic [PA_W-1:0] pa_pin_oe,
  input wire logic [PB_W-1:0] pb_dir,
  input wire logic [PB_W-1:0] pb_gen,
  input wire logic [PB_W-1:0] pb_pin_in,
  output logic [PB_W-1:0] pb_pin_out,
  output logic [PB_W-1:0] pb_pin_oe,
  input wire logic [PC_W-1:0] pc_dir,
  input wire logic [PC_W-1:0] pc_gen,
  input wire logic [PC_W-1:0] pc_pin_in,
  output logic [PC_W-1:0] pc_pin_out,
  output logic [PC_W-1:0] pc_pin_oe,
  input wire logic [15:0] pe_pin_in,
  output logic [15:0] pe_gen_sel,
  output logic [15:0] pe_fn_out,
  output logic [15:0] pe_fn_oe,
  input wire logic [6:0] host_if_data_out,
  input wire logic [6:0] host_if_data_oe,
  input wire logic host_if_interrupt,
  input wire logic host_if_transfer_request,
  input wire logic host_if_ready,
  input wire logic serial0_transmit,
  output logic [6:0] host_if_data_in,
  output logic host_if_chip_select,
  output logic host_if_reg_select,
  output logic host_if_write_strobe,
  output logic host_if_read_strobe,
  output logic host_if_enable,
  output logic host_if_mode_input
);

  // Port A and B fit one half word, port C needs a second one.
  // Wider ports would need more register words, which this map does not provide.
  if (PA_W < 1 || PA_W > `REG_W || PB_W < 1 || PB_W > `REG_W ||
      PC_W <= `PC_LOW_W || PC_W > 2 * `PC_LOW_W) begin : g_bad_width
    $error("port widths out of range");
  end

  // Data, selects, bus answer and pin routing share one register, so every output is a flip-flop.
  typedef struct packed {
    // Stored port data and function selects.
    logic [PA_W-1:0] pa;
    logic [PB_W-1:0] pb;
    logic [PC_W-1:0] pc;
    logic [15:0] fs1;
    logic [15:0] fs2;
    // Bus side: pending write and the answer of the current data phase.
    logic wr_pend;
    logic [`ADDR_W-1:0] addr;
    logic [31:0] rdata;
    logic ready;
    logic resp;
    // Pin side: registered drive enables and port E routing.
    logic [PA_W-1:0] pa_oe;
    logic [PB_W-1:0] pb_oe;
    logic [PC_W-1:0] pc_oe;
    logic [15:0] pe_gen;
    logic [15:0] pe_out;
    logic [15:0] pe_oe;
    // Host-interface inputs as taken from the pins.
    logic [6:0] hd_in;
    logic cs;
    logic rs;
    logic wr;
    logic rd;
    logic en;
    logic md;
  } state_t;

  state_t st_reg;
  state_t st_next;
  logic [PA_W-1:0] pa_oe_c, pa_mask, pa_live;
  logic [PB_W-1:0] pb_oe_c, pb_mask, pb_live;
  logic [PC_W-1:0] pc_oe_c, pc_mask, pc_live;

  // Read source per bit: live pin where masked, stored register elsewhere.
  // The pin level is the one sampled at the address edge, not in the data phase.
  function automatic logic [31:0] merge(input logic [31:0] data, input logic [31:0] mask,
                                        input logic [31:0] live);
    merge = (data & ~mask) | (live & mask);
  endfunction : merge

  // One bit per port E pin that is handed to the host interface.
  // Pin 15 has a two-bit field; every other pin has one bit at an even position.
  function automatic port_pfc_pkg::half_t host_sel(input port_pfc_pkg::half_t fs1,
                                                   input port_pfc_pkg::half_t fs2);
    port_pfc_pkg::half_t h;
    h = '0;
    h[`PE15_HI] = (port_pfc_pkg::pe15_func_t'(fs1[`PE15_HI:`PE15_LO]) ==
                   port_pfc_pkg::pe15_host);
    for (int i = 0; i < `FS1_SINGLE_PINS; i++) begin
      h[`FS1_FIRST_PIN + i] = fs1[2 * i];
    end
    for (int i = 0; i < `FS1_FIRST_PIN; i++) begin
      h[i] = fs2[2 * i];
    end
    host_sel = h;
  endfunction : host_sel

  // Each general port gets the same direction and read-source decode.
  port_pin_slice #(.W(PA_W)) u_slice_a (
    .dir(pa_dir),
    .gen(pa_gen),
    .pin_in(pa_pin_in),
    .oe(pa_oe_c),
    .live_mask(pa_mask),
    .live(pa_live)
  );
  port_pin_slice #(.W(PB_W)) u_slice_b (
    .dir(pb_dir),
    .gen(pb_gen),
    .pin_in(pb_pin_in),
    .oe(pb_oe_c),
    .live_mask(pb_mask),
    .live(pb_live)
  );
  port_pin_slice #(.W(PC_W)) u_slice_c (
    .dir(pc_dir),
    .gen(pc_gen),
    .pin_in(pc_pin_in),
    .oe(pc_oe_c),
    .live_mask(pc_mask),
    .live(pc_live)
  );

  // Next state: bus write, bus read capture, pin routing, and synchronous reset.
  always_comb begin
    port_pfc_pkg::half_t h;
    port_pfc_pkg::half_t wd;
    logic serial;
    logic accept;
    logic [31:0] pcv;
    h = '0;
    wd = '0;
    serial = 1'b0;
    accept = 1'b0;
    pcv = '0;
    st_next = st_reg;
    // Data phase of a write; reserved bits are dropped so they read back as zero.
    wd = hwdata[`REG_W-1:0];
    if (st_reg.wr_pend) begin
      case (st_reg.addr)
        `OFF_PA_DATA: st_next.pa = wd[PA_W-1:0];
        `OFF_PB_DATA: st_next.pb = wd[PB_W-1:0];
        `OFF_PC_HIGH: st_next.pc[PC_W-1:`PC_LOW_W] = wd[PC_W-`PC_LOW_W-1:0];
        `OFF_PC_LOW: st_next.pc[`PC_LOW_W-1:0] = wd;
        `OFF_PE_FS1: begin
          st_next.fs1 = wd & `FS1_MASK;
          // The prohibited code never reaches the mux; the old pin 15 field stays.
          if (port_pfc_pkg::pe15_func_t'(wd[`PE15_HI:`PE15_LO]) ==
              port_pfc_pkg::pe15_prohibited) begin
            st_next.fs1[`PE15_HI:`PE15_LO] = st_reg.fs1[`PE15_HI:`PE15_LO];
          end
        end
        `OFF_PE_FS2: st_next.fs2 = wd & `FS2_MASK;
        default: st_next.fs2 = st_reg.fs2;
      endcase
    end
    // Address phase; reads see a write finishing in this same cycle.
    // The slave never inserts wait states, so a transfer is taken on its first address edge.
    accept = hsel & hready & htrans[`HTRANS_ACTIVE_BIT];
    st_next.wr_pend = accept & hwrite;
    st_next.addr = haddr[`ADDR_W-1:0];
    // Read data stands for the data phase only and reads zero otherwise.
    st_next.rdata = '0;
    if (accept && !hwrite) begin
      pcv = merge(32'(st_next.pc), 32'(pc_mask), 32'(pc_live));
      case (haddr[`ADDR_W-1:0])
        `OFF_PA_DATA: st_next.rdata = merge(32'(st_next.pa), 32'(pa_mask), 32'(pa_live));
        `OFF_PB_DATA: st_next.rdata = merge(32'(st_next.pb), 32'(pb_mask), 32'(pb_live));
        `OFF_PC_HIGH: st_next.rdata = 32'(pcv[PC_W-1:`PC_LOW_W]);
        `OFF_PC_LOW: st_next.rdata = 32'(pcv[`PC_LOW_W-1:0]);
        `OFF_PE_FS1: st_next.rdata = 32'(st_next.fs1);
        `OFF_PE_FS2: st_next.rdata = 32'(st_next.fs2);
        default: st_next.rdata = '0;
      endcase
    end
    // Zero wait states and an OKAY answer on every transfer.
    st_next.ready = 1'b1;
    st_next.resp = `HRESP_OKAY;
    // Output enables follow the direction bits one cycle later.
    st_next.pa_oe = pa_oe_c;
    st_next.pb_oe = pb_oe_c;
    st_next.pc_oe = pc_oe_c;
    // Port E routing comes from the stored selects.
    // A select write therefore shows on the pins one clock after it is stored.
    h = host_sel(st_reg.fs1, st_reg.fs2);
    serial = (port_pfc_pkg::pe15_func_t'(st_reg.fs1[`PE15_HI:`PE15_LO]) ==
              port_pfc_pkg::pe15_serial);
    st_next.pe_gen = ~h;
    st_next.pe_gen[`PE_SERIAL_PIN] = ~h[`PE_SERIAL_PIN] & ~serial;
    st_next.pe_out = '0;
    st_next.pe_oe = '0;
    // Host data pins drive only where the host unit enables them; pin 15 is bit 6.
    for (int i = 0; i < `PE_HD_W; i++) begin
      st_next.pe_out[`PE_HD_BASE + i] = h[`PE_HD_BASE + i] & host_if_data_out[i];
      st_next.pe_oe[`PE_HD_BASE + i] = h[`PE_HD_BASE + i] & host_if_data_oe[i];
      st_next.hd_in[i] = h[`PE_HD_BASE + i] & pe_pin_in[`PE_HD_BASE + i];
    end
    // The serial transmit line always drives once pin 15 is handed to it.
    if (serial) begin
      st_next.pe_out[`PE_SERIAL_PIN] = serial0_transmit;
      st_next.pe_oe[`PE_SERIAL_PIN] = 1'b1;
    end
    st_next.pe_out[`PE_INT_PIN] = h[`PE_INT_PIN] & host_if_interrupt;
    st_next.pe_out[`PE_DREQ_PIN] = h[`PE_DREQ_PIN] & host_if_transfer_request;
    st_next.pe_out[`PE_RDY_PIN] = h[`PE_RDY_PIN] & host_if_ready;
    st_next.pe_oe[`PE_INT_PIN] = h[`PE_INT_PIN];
    st_next.pe_oe[`PE_DREQ_PIN] = h[`PE_DREQ_PIN];
    st_next.pe_oe[`PE_RDY_PIN] = h[`PE_RDY_PIN];
    // Deselected host inputs read low so the host unit sees no stray strobe.
    st_next.cs = h[`PE_CS_PIN] & pe_pin_in[`PE_CS_PIN];
    st_next.rs = h[`PE_RS_PIN] & pe_pin_in[`PE_RS_PIN];
    st_next.wr = h[`PE_WR_PIN] & pe_pin_in[`PE_WR_PIN];
    st_next.rd = h[`PE_RD_PIN] & pe_pin_in[`PE_RD_PIN];
    st_next.en = h[`PE_EN_PIN] & pe_pin_in[`PE_EN_PIN];
    st_next.md = h[`PE_MD_PIN] & pe_pin_in[`PE_MD_PIN];
    // The boot strap is sampled on the clock while reset is held.
    // Reset is applied last so that it wins over a write ending in the same cycle.
    if (rst) begin
      st_next = '0;
      st_next.pa = {PA_W{`DATA_RST_BIT}};
      st_next.pb = {PB_W{`DATA_RST_BIT}};
      st_next.pc = {PC_W{`DATA_RST_BIT}};
      st_next.fs1 = host_boot ? `FS1_RST_BOOT : `FS1_RST_NORM;
      st_next.fs2 = host_boot ? `FS2_RST_BOOT : `FS2_RST_NORM;
      st_next.pe_gen = '1;
      st_next.resp = `HRESP_OKAY;
      st_next.ready = 1'b1;
    end
  end

  // The whole block state is one register.
  // Reset is synchronous and already folded into the next state.
  always_ff @(posedge mclk) begin
    st_reg <= st_next;
  end

  // Every output is a field of the state register.
  assign hreadyout = st_reg.ready;
  assign hrdata = st_reg.rdata;
  assign hresp = st_reg.resp;

  // Port data drives; the enables decide whether a pin sees them.
  assign pa_pin_out = st_reg.pa;
  assign pa_pin_oe = st_reg.pa_oe;
  assign pb_pin_out = st_reg.pb;
  assign pb_pin_oe = st_reg.pb_oe;
  assign pc_pin_out = st_reg.pc;
  assign pc_pin_oe = st_reg.pc_oe;

  // Port E routing toward the pins and the external port E data logic.
  assign pe_gen_sel = st_reg.pe_gen;
  assign pe_fn_out = st_reg.pe_out;
  assign pe_fn_oe = st_reg.pe_oe;

  // Host-interface inputs, held low while their pins are in port use.
  assign host_if_data_in = st_reg.hd_in;
  assign host_if_chip_select = st_reg.cs;
  assign host_if_reg_select = st_reg.rs;
  assign host_if_write_strobe = st_reg.wr;
  assign host_if_read_strobe = st_reg.rd;
  assign host_if_enable = st_reg.en;
  assign host_if_mode_input = st_reg.md;

endmodule : port_data_and_pin_function

// >>> hdl/port_pfc_pkg.sv
package port_pfc_pkg;

  // Encoding of the two-bit function field of port E pin 15.
  typedef enum logic [1:0] {
    pe15_port = 2'b00,
    pe15_host = 2'b01,
    pe15_serial = 2'b10,
    pe15_prohibited = 2'b11
  } pe15_func_t;

  typedef logic [15:0] half_t;

endpackage : port_pfc_pkg

// >>> hdl/port_pfc_regs.svh
`ifndef PORT_PFC_REGS_SVH
`define PORT_PFC_REGS_SVH

// Byte offsets of the registers, compared against haddr[7:0].
`define OFF_PA_DATA 8'h00
`define OFF_PB_DATA 8'h04
`define OFF_PC_HIGH 8'h08
`define OFF_PC_LOW 8'h0c
`define OFF_PE_FS1 8'h10
`define OFF_PE_FS2 8'h14
`define ADDR_W 8

// Every register is a 16-bit half word in the low half of the bus word.
`define REG_W 16
`define PC_LOW_W 16

// Writable bits of the two function-select registers; the rest read as zero.
`define FS1_MASK 16'hd555
`define FS2_MASK 16'h5555

// Function-select reset values for normal boot and host-interface boot.
`define FS1_RST_NORM 16'h0000
`define FS1_RST_BOOT 16'h5555
`define FS2_RST_NORM 16'h0040
`define FS2_RST_BOOT 16'h5555

// Field positions in the function-select registers.
`define PE15_HI 15
`define PE15_LO 14
`define FS1_FIRST_PIN 8
`define FS1_SINGLE_PINS 7

// Pin positions of port E.
`define PE_SERIAL_PIN 15
`define PE_HD_BASE 9
`define PE_HD_W 7
`define PE_CS_PIN 8
`define PE_RS_PIN 7
`define PE_WR_PIN 6
`define PE_RD_PIN 5
`define PE_INT_PIN 4
`define PE_MD_PIN 3
`define PE_DREQ_PIN 2
`define PE_RDY_PIN 1
`define PE_EN_PIN 0
`define PE_W 16

// Bus constants and the data reset level.
`define HTRANS_ACTIVE_BIT 1
`define HRESP_OKAY 1'b0
`define DATA_RST_BIT 1'b0

`endif

// >>> hdl/port_pin_slice.sv
`timescale 1ns/10ps

// Direction and read-source decode for one general-purpose port.
module port_pin_slice #(
  parameter int W = 8
) (
  input wire logic [W-1:0] dir,
  input wire logic [W-1:0] gen,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] oe,
  output logic [W-1:0] live_mask,
  output logic [W-1:0] live
);

  // Only a pin in general port use obeys its direction bit.
  assign oe = gen & dir;
  // A general input returns its pin; outputs and other functions return the register.
  assign live_mask = gen & ~dir;
  assign live = pin_in & live_mask;

endmodule : port_pin_slice
